// ===== aux_step_config.sv
// axi4-lite register block for auxiliary converter sequencer steps 12/13
//
// Overview of operation
// - bit 15 enables the step, so the sequencer runs it only when set.
// - bits 14:13 pick gain 1 for 00b, 2 for 01b and 4 for 10b or 11b.
// - bits 12:5 are reserved and always read zero whatever is written.
// - bit 4 routes the ground reference when 0 and external input seven when 1.
// - positive codes 0000b to 0111b route external inputs zero to seven.
// - codes 1000b, 1001b, 1010b route sensor, short, test dac with auto negative.
// - codes 1100b, 1110b, 1111b route divided supplies with auto negative.
// - for any auto-negative positive code the negative select bit is ignored.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module aux_step_config
    import aux_step_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // decoded step 12 controls to the sequencer
    output var  logic              step12_enable,
    output var  logic [2:0]        step12_gain,
    output var  logic [3:0]        step12_positive_select,
    output var  neg_route_t        step12_negative_route,
    // decoded step 13 controls to the sequencer
    output var  logic              step13_enable,
    output var  logic [2:0]        step13_gain,
    output var  logic [3:0]        step13_positive_select,
    output var  neg_route_t        step13_negative_route
);

    // ----------------------------------------------------------
    // declarations
    // ----------------------------------------------------------
    localparam logic [ADDR_W-1:0] A_STEP12 = reg_addr(IDX_STEP12);
    localparam logic [ADDR_W-1:0] A_STEP13 = reg_addr(IDX_STEP13);
    localparam logic [ADDR_W-1:0] A_STAT   = reg_addr(IDX_ROUTE_STAT);

    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0]        wstrb_r;
    logic [CFG_W-1:0]  step12_cfg_r;
    logic [CFG_W-1:0]  step13_cfg_r;
    logic              wr_fire;
    logic [DATA_W-1:0] rd_nxt;
    logic [1:0]        rresp_nxt;

    // both write halves held and no response pending
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;

    // ----------------------------------------------------------
    // write channel handshakes
    // ----------------------------------------------------------
    // address and data taken in either order; ready drops until bresp
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            waddr_r   <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                waddr_r   <= s_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                if (waddr_r == A_STEP12 || waddr_r == A_STEP13
                    || waddr_r == A_STAT) begin
                    bresp_r <= RESP_OKAY;   // status writes are dropped
                end else begin
                    bresp_r <= RESP_SLVERR;
                end
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------
    // step configuration words
    // ----------------------------------------------------------
    // reserved bits are masked on the way in so they never hold ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step12_cfg_r <= RST_STEP12;
            step13_cfg_r <= RST_STEP13;
        end else if (wr_fire) begin
            if (waddr_r == A_STEP12) begin
                step12_cfg_r <= merge_cfg(step12_cfg_r, wdata_r,
                                          wstrb_r);
            end
            if (waddr_r == A_STEP13) begin
                step13_cfg_r <= merge_cfg(step13_cfg_r, wdata_r,
                                          wstrb_r);
            end
        end
    end

    // ----------------------------------------------------------
    // read data mux
    // ----------------------------------------------------------
    // status shows the decoded enable, gain and negative route the sequencer sees, but not the positive select
    always_comb begin
        rd_nxt    = '0;
        rresp_nxt = RESP_OKAY;
        case (s_axi_araddr)
            A_STEP12: rd_nxt[CFG_W-1:0] = step12_cfg_r;
            A_STEP13: rd_nxt[CFG_W-1:0] = step13_cfg_r;
            A_STAT: begin
                rd_nxt[0]   = step12_enable;
                rd_nxt[3:1] = step12_gain;
                rd_nxt[5:4] = step12_negative_route;
                rd_nxt[STAT_STEP13_LSB]     = step13_enable;
                rd_nxt[STAT_STEP13_LSB+1 +: 3] = step13_gain;
                rd_nxt[STAT_STEP13_LSB+4 +: 2] = step13_negative_route;
            end
            default: rresp_nxt = RESP_SLVERR;
        endcase
    end

    // ----------------------------------------------------------
    // read channel
    // ----------------------------------------------------------
    // one read outstanding; data registered one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end else begin
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_nxt;
                rresp_r   <= rresp_nxt;
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------
    // bus outputs
    // ----------------------------------------------------------
    // no logic between flop and pin, so bus timing stays clean
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // ----------------------------------------------------------
    // step decoders
    // ----------------------------------------------------------
    // decoded outputs lag a register write by one cycle
    aux_step_decode u_step12 (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .cfg           (step12_cfg_r),
        .step_enable_r (step12_enable),
        .gain_factor_r (step12_gain),
        .pos_select_r  (step12_positive_select),
        .neg_route_r   (step12_negative_route)
    );

    aux_step_decode u_step13 (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .cfg           (step13_cfg_r),
        .step_enable_r (step13_enable),
        .gain_factor_r (step13_gain),
        .pos_select_r  (step13_positive_select),
        .neg_route_r   (step13_negative_route)
    );

endmodule

`default_nettype wire

// ===== aux_step_pkg.sv
// constants and helpers for the auxiliary converter step configuration
package aux_step_pkg;

    // --------------------------------------------------------------
    // register map (indices; byte address is four times the index)
    // --------------------------------------------------------------
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned CFG_W           = 16;
    localparam logic [7:0]  IDX_STEP12      = 8'h9C;
    localparam logic [7:0]  IDX_STEP13      = 8'h9D;
    localparam logic [7:0]  IDX_ROUTE_STAT  = 8'hC0;
    localparam logic [1:0]  BYTE_OFFS       = 2'h0;

    // reset values
    localparam logic [CFG_W-1:0] RST_STEP12 = 16'h000C;
    localparam logic [CFG_W-1:0] RST_STEP13 = 16'h000D;

    // --------------------------------------------------------------
    // field layout of a step word
    // --------------------------------------------------------------
    localparam int unsigned EN_BIT          = 15;
    localparam int unsigned GAIN_HI         = 14;
    localparam int unsigned GAIN_LO         = 13;
    localparam int unsigned NEG_BIT         = 4;
    localparam int unsigned POS_HI          = 3;
    localparam int unsigned POS_LO          = 0;
    localparam int unsigned AUTO_BIT        = 3;
    localparam logic [CFG_W-1:0] CFG_WR_MASK = 16'hE01F;

    // gain codes and factors
    localparam logic [1:0] GAIN_CODE_X1     = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2     = 2'h1;
    localparam logic [2:0] GAIN_FACTOR_1    = 3'h1;
    localparam logic [2:0] GAIN_FACTOR_2    = 3'h2;
    localparam logic [2:0] GAIN_FACTOR_4    = 3'h4;

    // effective negative input routing
    typedef enum logic [1:0] {
        NEG_GROUND_REF = 2'b00,
        NEG_EXT_SEVEN  = 2'b01,
        NEG_AUTOMATIC  = 2'b10
    } neg_route_t;

    // status layout: one byte per step
    localparam int unsigned STAT_STEP13_LSB = 8;

    // axi responses
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'h0, idx, BYTE_OFFS};
    endfunction

    // positive codes 1000b and up pick the negative input themselves
    function automatic logic is_auto_neg(input logic [3:0] pos);
        return pos[AUTO_BIT];
    endfunction

    // merge a strobed write into a step word, reserved bits stay zero
    function automatic logic [CFG_W-1:0] merge_cfg(
        input logic [CFG_W-1:0] old_v,
        input logic [DATA_W-1:0] wd,
        input logic [3:0]        strb
    );
        logic [CFG_W-1:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & CFG_WR_MASK;
    endfunction

endpackage

// ===== aux_step_decode.sv
// registered decode of one sequencer step word into routing controls
`timescale 1ns/1ps
`default_nettype none

module aux_step_decode
    import aux_step_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [CFG_W-1:0] cfg,
    output var  logic             step_enable_r,
    output var  logic [2:0]       gain_factor_r,
    output var  logic [3:0]       pos_select_r,
    output var  neg_route_t       neg_route_r
);

    // ----------------------------------------------------------
    // decode
    // ----------------------------------------------------------
    // registered so the top drives its outputs straight from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_enable_r <= 1'b0;
            gain_factor_r <= GAIN_FACTOR_1;
            pos_select_r  <= RST_STEP12[POS_HI:POS_LO];
            neg_route_r   <= NEG_AUTOMATIC;
        end else begin
            step_enable_r <= cfg[EN_BIT];
            case (cfg[GAIN_HI:GAIN_LO])
                GAIN_CODE_X1: gain_factor_r <= GAIN_FACTOR_1;
                GAIN_CODE_X2: gain_factor_r <= GAIN_FACTOR_2;
                default:      gain_factor_r <= GAIN_FACTOR_4;
            endcase
            pos_select_r <= cfg[POS_HI:POS_LO];
            if (is_auto_neg(cfg[POS_HI:POS_LO])) begin
                neg_route_r <= NEG_AUTOMATIC;
            end else if (cfg[NEG_BIT]) begin
                neg_route_r <= NEG_EXT_SEVEN;
            end else begin
                neg_route_r <= NEG_GROUND_REF;
            end
        end
    end

endmodule

`default_nettype wire

// ===== aux_step_config_checker.sv
// assertion checker for the step configuration register block
`timescale 1ns/1ps
`default_nettype none

module aux_step_config_checker
    import aux_step_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              step12_enable,
    input wire logic [2:0]        step12_gain,
    input wire logic [3:0]        step12_positive_select,
    input wire neg_route_t        step12_negative_route
);
    logic       rd12_r;
    logic [1:0] gc;

    // read data is the step 12 cfg word only when step 12 was addressed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd12_r <= 1'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd12_r <= (s_axi_araddr == {2'h0, IDX_STEP12, 2'h0});
        end
    end
    assign gc = s_axi_rdata[14:13];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // reserved bits and decoded outputs against the word read back, legal gain values and reset
    // ------------------------------------------------------------
    a_reserved_zero: assert property (
        s_axi_rvalid && rd12_r |-> s_axi_rdata[12:5] == 8'h00)
        else $error("reserved bits read nonzero");
    a_enable_match: assert property (
        s_axi_rvalid && rd12_r |-> step12_enable == s_axi_rdata[15])
        else $error("enable output differs from word");
    a_gain_match: assert property (
        s_axi_rvalid && rd12_r |-> step12_gain ==
        ((gc == 2'h0) ? 3'h1 : (gc == 2'h1) ? 3'h2 : 3'h4))
        else $error("gain factor differs from code");
    a_gain_legal: assert property (
        step12_gain inside {3'h1, 3'h2, 3'h4})
        else $error("gain factor outside 1 2 4");
    a_pos_match: assert property (
        s_axi_rvalid && rd12_r |-> step12_positive_select ==
        s_axi_rdata[3:0])
        else $error("positive select differs from word");
    a_neg_manual: assert property (
        s_axi_rvalid && rd12_r && !s_axi_rdata[3] |->
        step12_negative_route == (s_axi_rdata[4] ? NEG_EXT_SEVEN
                                                 : NEG_GROUND_REF))
        else $error("negative route differs from bit");
    a_neg_auto: assert property (
        step12_positive_select[3] |->
        step12_negative_route == NEG_AUTOMATIC)
        else $error("negative route not automatic");
    a_reset_state: assert property (
        $rose(aresetn) |-> !step12_enable && step12_gain == 3'h1
        && step12_positive_select == 4'hC)
        else $error("step outputs wrong after reset");

    // main scenarios seen
    c_read12: cover property (s_axi_rvalid && rd12_r && step12_enable);
    c_auto: cover property (step12_positive_select[3] && step12_enable);
    c_ext7: cover property (step12_negative_route == NEG_EXT_SEVEN);
endmodule

bind aux_step_config aux_step_config_checker u_aux_step_config_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .step12_enable(step12_enable), .step12_gain(step12_gain),
    .step12_positive_select(step12_positive_select),
    .step12_negative_route(step12_negative_route)
);

`default_nettype wire

// ===== test_aux_step_config.sv
// self-checking bench for the step configuration register block
`timescale 1ns/1ps
`default_nettype none

module test_aux_step_config
    import aux_step_pkg::*;
();
    localparam logic [ADDR_W-1:0] A12 = {2'h0, IDX_STEP12, 2'h0};
    localparam logic [ADDR_W-1:0] A13 = {2'h0, IDX_STEP13, 2'h0};
    localparam logic [ADDR_W-1:0] AST = {2'h0, IDX_ROUTE_STAT, 2'h0};
    logic              aclk    = 1'h0;
    logic              aresetn = 1'h0;
    logic              awvalid = 1'h0;
    logic              wvalid  = 1'h0;
    logic              bready  = 1'h0;
    logic              arvalid = 1'h0;
    logic              rready  = 1'h0;
    logic [ADDR_W-1:0] awaddr  = 12'h000;
    logic [ADDR_W-1:0] araddr  = 12'h000;
    logic [DATA_W-1:0] wdata   = 32'h0;
    logic [3:0]        wstrb   = 4'h0;
    logic              awready, wready, bvalid, arready, rvalid, e12, e13;
    logic [1:0]        bresp, rresp;
    logic [DATA_W-1:0] rdata;
    logic [2:0]        g12, g13;
    logic [3:0]        p12, p13;
    neg_route_t        n12, n13;
    logic [9:0]        d12, d13;
    int                n_fail = 0;
    int                tests_run = 0;

    // 125 MHz
    always #4 aclk = ~aclk;
    assign d12 = {e12, g12, p12, n12};
    assign d13 = {e13, g13, p13, n13};

    aux_step_config u_aux_step_config (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .step12_enable(e12), .step12_gain(g12),
        .step12_positive_select(p12), .step12_negative_route(n12),
        .step13_enable(e13), .step13_gain(g13),
        .step13_positive_select(p13), .step13_negative_route(n13)
    );

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask

    // a hung handshake ends the run as a failure
    task automatic give_up();
        n_fail++;
        end_of_test();
    endtask

    // both channels offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'h1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (n == 64) give_up();
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (n == 64) give_up();
        rready <= 1'h0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // expected decode worked out from the cfg word alone
    task automatic chk_dec(input logic [15:0] w, input logic [9:0] got);
        logic [2:0] g;
        neg_route_t r;
        g = (w[14:13] == 2'h0) ? 3'h1 : (w[14:13] == 2'h1) ? 3'h2 : 3'h4;
        r = w[3] ? NEG_AUTOMATIC : (w[4] ? NEG_EXT_SEVEN : NEG_GROUND_REF);
        chk({22'h0, got}, {22'h0, w[15], g, w[3:0], r});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [15:0] w;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        chk_dec(16'h000C, d12);
        rd(A12, 32'h0000000C, RESP_OKAY);
        rd(A13, 32'h0000000D, RESP_OKAY);
        chk_dec(16'h000D, d13);
        $display("test reset done");
        // all codes back to back, reserved bits written high
        for (int i = 0; i < 16; i++) begin
            w = {i[0], i[2:1], 8'h00, i[1], i[3:0]};
            wr(A12, {16'hFFFF, w | 16'h1FE0}, 4'hF, RESP_OKAY);
            rd(A12, {16'h0, w}, RESP_OKAY);
            chk_dec(w, d12);
        end
        wr(A13, 32'h00008015, 4'hF, RESP_OKAY);
        rd(A13, 32'h00008015, RESP_OKAY);
        chk_dec(16'h8015, d13);
        $display("test sweep done");
        // one byte lane only, then an unmapped place
        wr(A12, 32'h12346000, 4'h2, RESP_OKAY);
        rd(A12, 32'h0000601F, RESP_OKAY);
        wr(12'h004, 32'h0000FFFF, 4'hF, RESP_SLVERR);
        rd(12'h004, 32'h00000000, RESP_SLVERR);
        rd(A12, 32'h0000601F, RESP_OKAY);
        rd(AST, 32'h00001328, RESP_OKAY);
        $display("test lanes done");
        end_of_test();
    end
endmodule

`default_nettype wire
